// File: src/asf_params.svh
// Purpose: constants of the converter status word block
// Assumes: 125 MHz core clock
// Notes: included by its bare name
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

// ----------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------
`define ASF_POS_HELD_IN_RESET_FLAG 22
`define ASF_POS_RDY_LO 16
`define ASF_POS_SCAN_SETUP_FAULT 15
`define ASF_POS_REFERENCE_PRESENT 14
`define ASF_POS_SEQUENCE_ORDER_FAULT 13
`define ASF_POS_OUTPUT_MAP_FAULT 12
`define ASF_POS_ERROR 11
`define ASF_POS_SYSTEM_GAIN_CAL_OVERRANGE 10
`define ASF_POS_DOR 9
`define ASF_POS_AOR 8
`define ASF_POS_RATE_LO 4
`define ASF_POS_PD_LO 2
`define ASF_POS_MODULATOR_BUSY 1
`define ASF_POS_DRDY 0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define ASF_RST_REFERENCE_PRESENT 1'b1
`define ASF_RST_FAULT 1'b0
`define ASF_PD_CONV 2'h0
`define ASF_PD_SLEEP 2'h1
`define ASF_PD_STANDBY 2'h2
`define ASF_PD_RESET 2'h3
`define ASF_POS_ILLEGAL_LO 3'h0
`define ASF_POS_ILLEGAL_HI 3'h7
`define ASF_CAL_ILLEGAL 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASF_CLK_PERIOD_NS 8
`define ASF_REF_VALID_NS 30000
`define ASF_REF_VALID_CYC (`ASF_REF_VALID_NS / `ASF_CLK_PERIOD_NS)

`endif

// File: src/asf_pkg.sv
// Purpose: types shared by the status word block
// Assumes: nothing
// Notes: constants live in asf_params.svh
package asf_pkg;
  typedef logic [2:0] asf_pos_t;
  typedef logic [1:0] asf_pin_t;
  typedef logic [1:0] asf_pd_t;
  typedef logic [23:0] asf_word_t;
  typedef logic [11:0] asf_age_t;
endpackage

// File: src/asf_sync2.sv
// Purpose: two flop synchroniser for pin levels
// Assumes: input is asynchronous to core_clk_i
// Notes: first stage feeds only the second
module asf_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // two stage capture
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// File: src/asf_status.sv
// What this block does
// (RL1) in-reset bit high in reset power state; word reads zero while rst_n_i low
// (RL2) modes 2/3 set ready per channel
// (RL3) ready clears after complete result read or on scan start
// (RL4) scan start clears those of the six ready flags not set by a new result that cycle
// (RL5) scan fault: none enabled or bad code
// (RL6) scan fault aborts every conversion command
// (RL7) reference bit follows reference above threshold
// (RL8) reference bit zero in sleep/standby, informational
// (RL9) reference bit valid within 30us of start
// (RL10) duplicate enabled order codes raise order fault
// (RL11) enabled code 000 or 111 raises fault
// (RL12) enabled codes must run gap-free from 001
// (RL13) order fault holds converter in standby
// (RL14) output pin clash faults and holds standby
// (RL15) calibration select 11 sets config fault
// (RL16) modes 2/3 without single cycle: fault
// (RL17) config fault forces standby
// (RL18) digital overrange bit follows clipped result
// (RL19) modulator busy during conversion or calibration
// (RL20) faults re-evaluated on each configuration write
//
// Purpose: status word and configuration checks of the converter
// Assumes: config and sequencer inputs on core_clk_i; ref pin async
// Notes: fault flags update on config_write_i only
`include "asf_params.svh"

module asf_status #(
  parameter int NCH = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] seq_mode_i,
  input wire logic [NCH-1:0] channel_scan_enable_i,
  input wire logic [3*NCH-1:0] channel_scan_position_i,
  input wire logic [NCH-1:0] channel_output_enable_i,
  input wire logic [2*NCH-1:0] general_output_pin_i,
  input wire logic [1:0] cal_select_i,
  input wire logic single_cycle_select_i,
  input wire logic config_write_i,
  input wire logic [NCH-1:0] result_new_i,
  input wire logic [NCH-1:0] result_read_done_i,
  input wire logic scan_start_i,
  input wire logic conv_cmd_i,
  input wire logic conversion_start_i,
  input wire logic ref_ok_pin_i,
  input wire logic [1:0] power_state_i,
  input wire logic conv_busy_i,
  input wire logic self_cal_busy_i,
  input wire logic sys_cal_busy_i,
  input wire logic result_clipped_i,
  input wire logic result_valid_i,
  input wire logic analog_overrange_i,
  input wire logic system_gain_cal_overrange_i,
  input wire logic [3:0] rate_i,
  input wire logic data_ready_i,
  output logic conv_abort_o,
  output logic force_standby_o,
  output logic ref_valid_o,
  output logic [23:0] converter_status_word_o
);
  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic asf_pkg::asf_pos_t pos_of(input logic [3*NCH-1:0] v, input int i);
    pos_of = v[3*i +: 3];
  endfunction

  function automatic logic pos_illegal(input asf_pkg::asf_pos_t p);
    pos_illegal = (p == `ASF_POS_ILLEGAL_LO) || (p == `ASF_POS_ILLEGAL_HI);
  endfunction

  function automatic logic scan_mode(input logic [1:0] m);
    scan_mode = m[1];
  endfunction

  // ----------------------------------------------------------------
  // configuration checks
  // ----------------------------------------------------------------
  logic any_illegal;
  logic order_dup;
  logic order_gap;
  logic map_clash;
  logic [7:0] seen;
  int unsigned n_en;

  // order code checks over enabled channels
  always_comb begin
    any_illegal = 1'b0;
    order_dup = 1'b0;
    order_gap = 1'b0;
    seen = 8'h00;
    n_en = 0;
    for (int i = 0; i < NCH; i++) begin
      if (channel_scan_enable_i[i]) begin
        n_en = n_en + 1;
        if (pos_illegal(pos_of(channel_scan_position_i, i))) any_illegal = 1'b1; // [RL11]
        if (seen[pos_of(channel_scan_position_i, i)]) order_dup = 1'b1; // [RL10]
        seen[pos_of(channel_scan_position_i, i)] = 1'b1;
      end
    end
    for (int k = 1; k <= NCH; k++) begin
      if (seen[k] != (k <= n_en)) order_gap = 1'b1; // [RL12]
    end
  end

  // output pin clash between output enabled channels
  always_comb begin
    map_clash = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      for (int j = i + 1; j < NCH; j++) begin
        if (channel_output_enable_i[i] && channel_output_enable_i[j] &&
            general_output_pin_i[2*i +: 2] == general_output_pin_i[2*j +: 2]) begin
          map_clash = 1'b1; // [RL14]
        end
      end
    end
  end

  logic scan_fault_nxt;
  logic order_fault_nxt;
  logic config_fault_nxt;

  // fault conditions as seen by the next configuration write
  assign scan_fault_nxt = scan_mode(seq_mode_i) && (channel_scan_enable_i == '0 || any_illegal); // [RL5]
  assign order_fault_nxt = order_dup || any_illegal || order_gap; // [RL10] [RL11] [RL12]
  assign config_fault_nxt = (cal_select_i == `ASF_CAL_ILLEGAL) || // [RL15]
                            (scan_mode(seq_mode_i) && !single_cycle_select_i); // [RL16]

  // ----------------------------------------------------------------
  // fault flags
  // ----------------------------------------------------------------
  logic scan_setup_fault_r;
  logic sequence_order_fault_r;
  logic output_map_fault_r;
  logic config_fault_r;

  // latch faults on every configuration write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      scan_setup_fault_r <= `ASF_RST_FAULT;
      sequence_order_fault_r <= `ASF_RST_FAULT;
      output_map_fault_r <= `ASF_RST_FAULT;
      config_fault_r <= `ASF_RST_FAULT;
    end else if (config_write_i) begin
      scan_setup_fault_r <= scan_fault_nxt; // [RL20]
      sequence_order_fault_r <= order_fault_nxt; // [RL20]
      output_map_fault_r <= map_clash; // [RL20]
      config_fault_r <= config_fault_nxt; // [RL20]
    end
  end

  // conversion refusal and standby hold
  assign conv_abort_o = conv_cmd_i && scan_setup_fault_r; // [RL6]
  assign force_standby_o = sequence_order_fault_r || output_map_fault_r || config_fault_r; // [RL13] [RL14] [RL17]

  // ----------------------------------------------------------------
  // channel ready flags
  // ----------------------------------------------------------------
  logic [NCH-1:0] channel_result_ready_r;

  // set wins over read clear and scan start clear
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_rdy
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          channel_result_ready_r[c] <= 1'b0;
        end else if (result_new_i[c] && scan_mode(seq_mode_i)) begin
          channel_result_ready_r[c] <= 1'b1; // [RL2]
        end else if (scan_start_i) begin
          channel_result_ready_r[c] <= 1'b0; // [RL4]
        end else if (result_read_done_i[c]) begin
          channel_result_ready_r[c] <= 1'b0; // [RL3]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // reference detect
  // ----------------------------------------------------------------
  logic ref_ok_sync;
  logic reference_present_r;
  asf_pkg::asf_age_t ref_age_r;

  asf_sync2 #(
    .W(1)
  ) u_ref_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(ref_ok_pin_i),
    .sync_o(ref_ok_sync)
  );

  // comparator level, forced low in sleep and standby
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reference_present_r <= `ASF_RST_REFERENCE_PRESENT;
    end else if (power_state_i == `ASF_PD_SLEEP || power_state_i == `ASF_PD_STANDBY) begin
      reference_present_r <= 1'b0; // [RL8]
    end else begin
      reference_present_r <= ref_ok_sync; // [RL7]
    end
  end

  // age since conversion start, saturating
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_age_r <= '0;
    end else if (conversion_start_i) begin
      ref_age_r <= '0;
    end else if (ref_age_r != 12'hfff) begin
      ref_age_r <= ref_age_r + 12'h001;
    end
  end

  // bit is trusted three edges after the start, well inside the limit
  assign ref_valid_o = (power_state_i == `ASF_PD_CONV) && (ref_age_r >= 12'h003); // [RL9]

  // ----------------------------------------------------------------
  // remaining status bits
  // ----------------------------------------------------------------
  logic held_in_reset_flag_r;
  logic digital_overrange_r;
  logic modulator_busy_r;

  // in-reset indication
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      held_in_reset_flag_r <= 1'b1; // [RL1]
    end else begin
      held_in_reset_flag_r <= (power_state_i == `ASF_PD_RESET); // [RL1]
    end
  end

  // overrange follows each new result
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      digital_overrange_r <= 1'b0;
    end else if (result_valid_i) begin
      digital_overrange_r <= result_clipped_i; // [RL18]
    end
  end

  // modulator activity
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      modulator_busy_r <= 1'b0;
    end else begin
      modulator_busy_r <= conv_busy_i || self_cal_busy_i || sys_cal_busy_i; // [RL19]
    end
  end

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  asf_pkg::asf_word_t word_nxt;

  // pack fields into word layout
  always_comb begin
    word_nxt = '0;
    word_nxt[`ASF_POS_HELD_IN_RESET_FLAG] = held_in_reset_flag_r;
    word_nxt[`ASF_POS_RDY_LO +: NCH] = channel_result_ready_r;
    word_nxt[`ASF_POS_SCAN_SETUP_FAULT] = scan_setup_fault_r;
    word_nxt[`ASF_POS_REFERENCE_PRESENT] = reference_present_r;
    word_nxt[`ASF_POS_SEQUENCE_ORDER_FAULT] = sequence_order_fault_r;
    word_nxt[`ASF_POS_OUTPUT_MAP_FAULT] = output_map_fault_r;
    word_nxt[`ASF_POS_ERROR] = config_fault_r;
    word_nxt[`ASF_POS_SYSTEM_GAIN_CAL_OVERRANGE] = system_gain_cal_overrange_i;
    word_nxt[`ASF_POS_DOR] = digital_overrange_r;
    word_nxt[`ASF_POS_AOR] = analog_overrange_i;
    word_nxt[`ASF_POS_RATE_LO +: 4] = rate_i;
    word_nxt[`ASF_POS_PD_LO +: 2] = power_state_i;
    word_nxt[`ASF_POS_MODULATOR_BUSY] = modulator_busy_r;
    word_nxt[`ASF_POS_DRDY] = data_ready_i;
  end

  // registered status word
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      converter_status_word_o <= '0;
    end else begin
      converter_status_word_o <= word_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_held_in_reset_flag_follows: assert property ( // [RL1]
    (power_state_i == `ASF_PD_RESET) |=> held_in_reset_flag_r)
    else $error("in-reset bit not set in reset state");

  a_ready_sets: assert property ( // [RL2]
    (result_new_i[0] && seq_mode_i[1]) |=> channel_result_ready_r[0])
    else $error("ready flag not set on new result");

  a_ready_holds: assert property ( // [RL3]
    (channel_result_ready_r[1] && !result_read_done_i[1] && !scan_start_i) |=> channel_result_ready_r[1])
    else $error("ready flag cleared without full read");

  a_scan_clears: assert property ( // [RL4]
    (scan_start_i && result_new_i == '0) |=> (channel_result_ready_r == '0))
    else $error("scan start left a ready flag set");

  a_scan_fault_set: assert property ( // [RL5]
    (config_write_i && seq_mode_i[1] && channel_scan_enable_i == '0) |=> scan_setup_fault_r)
    else $error("scan fault missed with no channel enabled");

  a_abort_cmd: assert property ( // [RL6]
    (conv_cmd_i && scan_setup_fault_r) |-> conv_abort_o)
    else $error("conversion command not aborted");

  a_ref_standby: assert property ( // [RL8]
    (power_state_i == `ASF_PD_STANDBY) [*3] |-> !converter_status_word_o[`ASF_POS_REFERENCE_PRESENT])
    else $error("reference bit high in standby");

  a_ref_deadline: assert property ( // [RL9]
    (power_state_i == `ASF_PD_CONV && ref_age_r >= `ASF_REF_VALID_CYC) |-> ref_valid_o)
    else $error("reference bit not valid in time");

  a_order_standby: assert property ( // [RL13]
    (config_write_i && order_fault_nxt) |=> force_standby_o until_with config_write_i)
    else $error("order fault did not hold standby");

  a_config_fault: assert property ( // [RL15]
    (config_write_i && cal_select_i == `ASF_CAL_ILLEGAL) |=> ##1 converter_status_word_o[`ASF_POS_ERROR])
    else $error("calibration select fault not reported");

  a_busy_bit: assert property ( // [RL19]
    (sys_cal_busy_i) |=> ##1 converter_status_word_o[`ASF_POS_MODULATOR_BUSY])
    else $error("modulator busy not reported");

  c_scan_fault: cover property (config_write_i && scan_fault_nxt);
  c_order_dup: cover property (config_write_i && order_dup);
  c_map_clash: cover property (config_write_i && map_clash);
  c_ready_read: cover property (channel_result_ready_r[0] ##1 result_read_done_i[0]);
endmodule

// File: sim/asf_host_model.sv
// Purpose: host side reader of the converter status word
// Assumes: word taken at the next falling edge, settled there
// Notes: behavioural, no serial timing modelled
module asf_host_model (
  input wire logic core_clk_i,
  input wire logic ref_valid_i,
  input wire logic [23:0] converter_status_word_i,
  output logic ref_trust_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // reference bit only trusted inside conversion window
  assign ref_trust_o = ref_valid_i;
  // one full status word read
  task automatic read_word(output logic [23:0] w);
    @(negedge core_clk_i);
    w = converter_status_word_i;
  endtask
endmodule

// File: sim/tb_adc_status_flags_checker.sv
// Purpose: self-checking bench of the status word block
// Assumes: inputs driven at falling edge of a 125 MHz clock
// Notes: words read through the host model
module tb_adc_status_flags_checker;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode = 2'h0, cal = 2'h0, pst = 2'h0;
  logic [5:0] en = 6'h00, oe = 6'h00, rnew = 6'h00, rdone = 6'h00;
  logic [17:0] pos = 18'h00000;
  logic [11:0] pin = 12'h000;
  logic sc = 1'b1, cfg_wr = 1'b0, scan_st = 1'b0, cmd = 1'b0, cstart = 1'b0, ref_pin = 1'b1;
  logic cbusy = 1'b0, clip = 1'b0, rvalid = 1'b0, scal = 1'b0;
  logic abort, stby, rvld, trust;
  logic [23:0] word, w;
  int num_errors = 0;
  int compares = 0;
  always #4 clk = ~clk;
  asf_status uut (.core_clk_i(clk), .rst_n_i(rst_n), .seq_mode_i(mode), .channel_scan_enable_i(en),
    .channel_scan_position_i(pos), .channel_output_enable_i(oe), .general_output_pin_i(pin),
    .cal_select_i(cal), .single_cycle_select_i(sc), .config_write_i(cfg_wr), .result_new_i(rnew),
    .result_read_done_i(rdone), .scan_start_i(scan_st), .conv_cmd_i(cmd), .conversion_start_i(cstart),
    .ref_ok_pin_i(ref_pin), .power_state_i(pst), .conv_busy_i(cbusy), .self_cal_busy_i(1'b0),
    .sys_cal_busy_i(scal), .result_clipped_i(clip), .result_valid_i(rvalid), .analog_overrange_i(1'b0),
    .system_gain_cal_overrange_i(1'b0), .rate_i(4'h5), .data_ready_i(1'b0), .conv_abort_o(abort),
    .force_standby_o(stby), .ref_valid_o(rvld), .converter_status_word_o(word));
  asf_host_model host (.core_clk_i(clk), .ref_valid_i(rvld), .converter_status_word_i(word),
    .ref_trust_o(trust));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic rd();
    repeat (6) @(negedge clk);
    host.read_word(w);
  endtask
  task automatic cfg(input logic [1:0] m, input logic [5:0] e, input logic [17:0] p,
                     input logic [5:0] o, input logic [11:0] pn, input logic [1:0] c, input logic s);
    @(negedge clk);
    mode = m; en = e; pos = p; oe = o; pin = pn; cal = c; sc = s; cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    rd();
  endtask
  // faults as {scan, order, map, config}
  task automatic chkf(input logic [3:0] f);
    `CHK({w[15], w[13], w[12], w[11]}, f)
    `CHK(stby, |f[2:0])
  endtask
  task automatic pulse_new(input logic [5:0] n, input logic [5:0] d, input logic s);
    @(negedge clk);
    rnew = n; rdone = d; scan_st = s;
    @(negedge clk);
    rnew = 6'h00; rdone = 6'h00; scan_st = 1'b0;
    rd();
  endtask
  task automatic end_of_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    pst = 2'h3;
    rd();
    `CHK(w[22], 1'b1)
    pst = 2'h0;
    rd();
    `CHK(w[22], 1'b0)
    `CHK(w[14], 1'b1)
    $display("reset and state done");
    cfg(2'h2, 6'h07, 18'h000d1, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'h0);
    cfg(2'h2, 6'h00, 18'h000d1, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'h8);
    @(negedge clk);
    cmd = 1'b1;
    #1 `CHK(abort, 1'b1)
    @(negedge clk);
    cmd = 1'b0;
    cfg(2'h3, 6'h01, 18'h00000, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'hc);
    cfg(2'h2, 6'h01, 18'h00007, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'hc);
    cfg(2'h2, 6'h03, 18'h00009, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'h4);
    cfg(2'h2, 6'h03, 18'h00019, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'h4);
    cfg(2'h2, 6'h07, 18'h000d1, 6'h03, 12'h000, 2'h0, 1'b1); chkf(4'h2);
    cfg(2'h2, 6'h07, 18'h000d1, 6'h03, 12'h004, 2'h3, 1'b1); chkf(4'h1);
    cfg(2'h3, 6'h07, 18'h000d1, 6'h00, 12'h000, 2'h0, 1'b0); chkf(4'h1);
    cfg(2'h2, 6'h0f, 18'h008d1, 6'h00, 12'h000, 2'h0, 1'b1); chkf(4'h0);
    @(negedge clk);
    cmd = 1'b1;
    #1 `CHK(abort, 1'b0)
    @(negedge clk);
    cmd = 1'b0;
    $display("config checks done");
    pulse_new(6'h08, 6'h00, 1'b0);
    `CHK(w[21:16], 6'h08)
    pulse_new(6'h12, 6'h00, 1'b0);
    `CHK(w[21:16], 6'h1a)
    pulse_new(6'h00, 6'h08, 1'b0);
    `CHK(w[21:16], 6'h12)
    pulse_new(6'h00, 6'h00, 1'b1);
    `CHK(w[21:16], 6'h00)
    mode = 2'h1;
    pulse_new(6'h01, 6'h00, 1'b0);
    `CHK(w[21:16], 6'h00)
    $display("ready flags done");
    clip = 1'b1; rvalid = 1'b1; cbusy = 1'b1;
    @(negedge clk);
    rvalid = 1'b0;
    rd();
    `CHK({w[9], w[1]}, 2'h3)
    clip = 1'b0; rvalid = 1'b1; cbusy = 1'b0; scal = 1'b1;
    @(negedge clk);
    rvalid = 1'b0;
    rd();
    `CHK({w[9], w[1]}, 2'h1)
    scal = 1'b0;
    rd();
    `CHK(w[1], 1'b0)
    cstart = 1'b1;
    @(negedge clk);
    cstart = 1'b0;
    repeat (3750) @(negedge clk);
    `CHK(trust, 1'b1)
    ref_pin = 1'b0;
    rd();
    `CHK(w[14], 1'b0)
    ref_pin = 1'b1;
    pst = 2'h2;
    rd();
    `CHK({w[14], w[3:2]}, 3'h2)
    `CHK(rvld, 1'b0)
    pst = 2'h1;
    rd();
    `CHK({w[14], w[3:2]}, 3'h1)
    $display("status bits done");
    end_of_test();
  end
  // hang guard, well beyond the expected 3960 cycles
  initial begin
    #160000;
    num_errors++;
    end_of_test();
  end
endmodule
